/* File: design/motor_guard_pkg.sv */
package motor_guard_pkg;
	localparam int CLK_MHZ       = 125;
	localparam int CLK_PERIOD_NS = 8;
	localparam int PWM_BASE_KHZ  = 25;
	localparam int PWM_BASE_CYC  = CLK_MHZ * 1000 / PWM_BASE_KHZ;
	localparam int PWM_CNT_W     = 13;
	localparam int DT_STEP_NS    = 40;
	localparam int DT_STEP_CYC   = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DT_CNT_W      = 7;
	localparam int AVS_IND_NS    = 2000;
	localparam int AVS_IND_CYC   = AVS_IND_NS / CLK_PERIOD_NS;
	localparam int KT_SHIFT      = 6;
	localparam int RM_SHIFT      = 6;
	localparam int KTC_SHIFT     = 8;
	localparam int COMM_W        = 20;
	// currents in mA, supply in mV
	localparam logic [11:0] NO_MOTOR_MA      = 12'h08C;
	localparam logic [11:0] LOCK_CUR_STEP_MA = 12'h190;
	localparam logic [15:0] SURGE_SUPPLY_MV  = 16'h5DC0;
	localparam int FB_CURRENT = 0;
	localparam int FB_SPEED   = 1;
	localparam int FB_KT      = 2;
	localparam int FB_NOMOTOR = 3;
	localparam int FB_OPEN    = 4;
	localparam int FB_CLOSED  = 5;
	localparam logic [1:0] OL_PULSE = 2'h0;
	localparam logic [1:0] OL_FIRST = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_OPEN   = 4'h2,
		ST_CLOSED = 4'h4,
		ST_OFF    = 4'h8
	} run_state_e;

	typedef enum logic [2:0] {
		BR_DRIVE = 3'h1,
		BR_BRAKE = 3'h2,
		BR_HIZ   = 3'h4
	} bridge_mode_e;

	// tacho period and high time, counted in electrical half cycles
	function automatic logic [2:0] tacho_period(input logic [1:0] sel);
		case (sel)
			2'h0: return 3'h2;
			2'h1: return 3'h3;
			2'h2: return 3'h4;
			default: return 3'h6;
		endcase
	endfunction

	function automatic logic [2:0] tacho_high(input logic [1:0] sel);
		case (sel)
			2'h0: return 3'h1;
			2'h1: return 3'h1;
			2'h2: return 3'h2;
			default: return 3'h3;
		endcase
	endfunction
endpackage

/* File: design/tacho_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module tacho_divider (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// half-cycle events and ratio
	input  wire logic       half_pulse,
	input  wire logic [1:0] ratio_sel,
	// divided level
	output logic            level
);
	import motor_guard_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic       lvl;
	} state_s;

	state_s q;
	state_s n;

	always_comb begin
		n = q;
		if (q.cnt >= tacho_period(ratio_sel)) begin
			n.cnt = 3'h0;
		end else if (half_pulse) begin
			n.cnt = (q.cnt == tacho_period(ratio_sel) - 3'h1) ? 3'h0 : q.cnt + 3'h1;
		end
		n.lvl = (n.cnt < tacho_high(ratio_sel));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// idle level is high, so no false edge after reset
			q <= '{lvl: 1'b1, default: '0};
		end else begin
			q <= n;
		end
	end

	assign level = q.lvl;
endmodule
`default_nettype wire

/* File: design/pwm_bridge_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_bridge_timing #(
	parameter int BASE_CYC = motor_guard_pkg::PWM_BASE_CYC
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	// configuration
	input  wire logic                        rate_double,
	input  wire logic [3:0]                  dead_sel,
	// drive request
	input  wire motor_guard_pkg::bridge_mode_e mode,
	input  wire logic [2:0][7:0]             duty,
	// gate drives
	output logic [2:0]                       gate_hi,
	output logic [2:0]                       gate_lo
);
	import motor_guard_pkg::*;

	typedef struct packed {
		logic [PWM_CNT_W-1:0]     cnt;
		logic [2:0]               want;
		logic [2:0][DT_CNT_W-1:0] dt;
		bridge_mode_e             mode;
		logic [2:0]               hi;
		logic [2:0]               lo;
	} state_s;

	state_s q;
	state_s n;

	always_comb begin
		logic [PWM_CNT_W-1:0] period;
		logic [DT_CNT_W-1:0]  dt_cyc;
		logic [20:0]          thr;
		n      = q;
		period = rate_double ? PWM_CNT_W'(BASE_CYC / 2) : PWM_CNT_W'(BASE_CYC);
		dt_cyc = DT_CNT_W'((32'(dead_sel) + 32'h1) * DT_STEP_CYC);
		thr    = 21'h0;
		n.mode = mode;
		n.cnt  = (q.cnt >= period - PWM_CNT_W'(1)) ? '0 : q.cnt + PWM_CNT_W'(1);
		for (int i = 0; i < 3; i++) begin
			thr = 21'(duty[i]) * 21'(period);
			n.want[i] = (q.cnt < thr[20:8]);
			if (q.dt[i] != '0) begin
				n.dt[i] = q.dt[i] - DT_CNT_W'(1);
			end
			// both gates off for the dead time on every edge; a mode change shows the new mode's gates for one cycle before it
			if (n.want[i] != q.want[i] || mode != q.mode) begin
				n.dt[i] = dt_cyc;
			end
			n.hi[i] = (mode == BR_DRIVE) && q.want[i] && (q.dt[i] == '0);
			n.lo[i] = (q.dt[i] == '0) &&
				((mode == BR_BRAKE) || (mode == BR_DRIVE && !q.want[i]));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{mode: BR_HIZ, default: '0};
		end else begin
			q <= n;
		end
	end

	assign gate_hi = q.hi;
	assign gate_lo = q.lo;
endmodule
`default_nettype wire

/* File: design/motor_lock_guard.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_lock_guard #(
	parameter int PWM_BASE_CYC = motor_guard_pkg::PWM_BASE_CYC,
	parameter int LOCK_WIN_CYC = 125000,
	parameter int LOCK_OFF_CYC = 625000
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	// configuration
	input  wire logic [2:0]            lock_current_threshold,
	input  wire logic [6:0]            phase_resistance_setting,
	input  wire logic [6:0]            bemf_constant_setting,
	input  wire logic [1:0]            bemf_band_threshold,
	input  wire logic [5:0]            lock_detector_enables,
	input  wire logic                  mech_surge_guard_enable,
	input  wire logic                  inductive_surge_guard_enable,
	input  wire logic                  mech_surge_guard_mode,
	input  wire logic [3:0]            dead_time_select,
	input  wire logic                  pwm_rate_double,
	input  wire logic [1:0]            tacho_ratio_select,
	input  wire logic [1:0]            tacho_open_loop_select,
	// command
	input  wire logic                  run_enable,
	input  wire logic [7:0]            speed_cmd,
	input  wire logic [2:0][7:0]       phase_wave,
	// motor estimates
	input  wire logic [11:0]           low_side_current,
	input  wire logic [11:0]           phase_u_current,
	input  wire logic [11:0]           speed_est,
	input  wire logic [15:0]           ktc_value,
	input  wire logic                  ktc_valid,
	input  wire logic [15:0]           supply_mv,
	input  wire logic                  ol_rate_reached,
	input  wire logic                  drive_half,
	input  wire logic                  bemf_zero_cross,
	input  wire logic                  commutation,
	// protection pins
	input  wire logic                  overheat_pin,
	input  wire logic                  overcurrent_pin,
	// bridge
	output logic [2:0]                 gate_hi,
	output logic [2:0]                 gate_lo,
	output motor_guard_pkg::bridge_mode_e bridge_mode,
	output logic [7:0]                 spd_buf,
	// status
	output logic                       tacho_output,
	output logic                       rotor_locked_flag,
	output logic [5:0]                 fault_cause_bits,
	output logic                       overheat_flag,
	output logic                       overcurrent_flag,
	output logic                       standby_flag
);
	import motor_guard_pkg::*;

	localparam int WIN_W = $clog2(LOCK_WIN_CYC + 1);
	localparam int OFF_W = $clog2(LOCK_OFF_CYC + 1);
	localparam logic [WIN_W-1:0] WIN_MAX = WIN_W'(LOCK_WIN_CYC);
	localparam logic [OFF_W-1:0] OFF_MAX = OFF_W'(LOCK_OFF_CYC);
	localparam logic [7:0]       AVS_CYC = 8'(AVS_IND_CYC);

	typedef struct packed {
		run_state_e         st;
		bridge_mode_e       mode;
		logic [7:0]         avs_cnt;
		logic [OFF_W-1:0]   off_cnt;
		logic [WIN_W-1:0]   win1;
		logic [WIN_W-1:0]   win2;
		logic [COMM_W-1:0]  comm_cnt;
		logic [COMM_W-1:0]  comm_prev;
		logic               prev_ok;
		logic               ktc_ok;
		logic               armed;
		logic               zc_seen;
		logic               halves;
		logic               first_done;
		logic [5:0]         faults;
		logic               locked;
		logic [7:0]         spd_buf;
		logic [2:0]         oc_s;
		logic [2:0]         ot_s;
		logic               oc;
		logic               ot;
		logic               tacho;
	} state_s;

	state_s          q;
	state_s          n;
	logic            div_lvl;
	logic            half_src;
	logic            ol_quiet_w;
	logic [2:0][7:0] scaled_duty;

	// estimate scaling: product of a 12-bit quantity and a 7-bit setting
	function automatic logic [18:0] scale(input logic [11:0] a, input logic [6:0] b, input int sh);
		logic [18:0] p;
		p = 19'(a) * 19'(b);
		return p >> sh;
	endfunction

	// ------------------------------------------------------------
	// detectors, sequencing, surge guard
	// ------------------------------------------------------------
	always_comb begin
		logic [18:0] kt_bemf;
		logic [18:0] rm_drop;
		logic [18:0] amp;
		logic [18:0] rm_bemf;
		logic [16:0] nom;
		logic [16:0] tol;
		logic [7:0]  floor8;
		logic [5:0]  hit;
		logic        cond1;
		logic        cond2;
		logic        clear;
		logic        floor_on;
		logic        ol_quiet;
		n        = q;
		kt_bemf  = scale(speed_est, bemf_constant_setting, KT_SHIFT);
		rm_drop  = scale(phase_u_current, phase_resistance_setting, RM_SHIFT);
		amp      = 19'(q.spd_buf);
		rm_bemf  = (rm_drop < amp) ? amp - rm_drop : 19'h0;
		nom      = 17'(bemf_constant_setting) << KTC_SHIFT;
		tol      = nom >> (2'h3 - bemf_band_threshold);
		floor8   = (kt_bemf > 19'h000FF) ? 8'hFF : kt_bemf[7:0];
		hit      = 6'h00;
		clear    = 1'b0;
		floor_on = 1'b0;
		ol_quiet = (tacho_open_loop_select != OL_PULSE) &&
			!(tacho_open_loop_select == OL_FIRST && !q.first_done);
		// speed-based bemf well above amplitude and above the current-based estimate
		cond1 = (kt_bemf > amp + (amp >> 2)) && (kt_bemf > rm_bemf);
		cond2 = q.ktc_ok && ((17'(ktc_value) < nom - tol) || (17'(ktc_value) > nom + tol));

		// protection pins: three flops, a change counts once the last two agree
		n.oc_s = {q.oc_s[1:0], overcurrent_pin};
		n.ot_s = {q.ot_s[1:0], overheat_pin};
		if (q.oc_s[1] == q.oc_s[2]) begin
			n.oc = q.oc_s[2];
		end
		if (q.ot_s[1] == q.ot_s[2]) begin
			n.ot = q.ot_s[2];
		end

		case (q.st)
			ST_IDLE: begin
				if (run_enable) begin
					n.st  = ST_OPEN;
					clear = 1'b1;
				end
			end
			ST_OPEN: begin
				hit[FB_CURRENT] = low_side_current >
					12'((16'(lock_current_threshold) + 16'h1) * 16'(LOCK_CUR_STEP_MA));
				if (ol_rate_reached) begin
					n.armed = 1'b1;
				end
				if (q.armed && bemf_zero_cross) begin
					n.zc_seen = 1'b1;
				end
				if (q.armed && drive_half) begin
					n.halves = ~q.halves;
					if (q.halves) begin
						// one full electrical cycle since the handoff rate was passed
						n.zc_seen = 1'b0;
						if (q.zc_seen || bemf_zero_cross) begin
							n.st            = ST_CLOSED;
							n.first_done    = 1'b1;
							n.comm_cnt      = '0;
							n.prev_ok       = 1'b0;
							n.ktc_ok        = 1'b0;
							hit[FB_NOMOTOR] = (phase_u_current <= NO_MOTOR_MA);
						end else begin
							hit[FB_OPEN] = 1'b1;
						end
					end
				end
			end
			ST_CLOSED: begin
				hit[FB_CURRENT] = low_side_current >
					12'((16'(lock_current_threshold) + 16'h1) * 16'(LOCK_CUR_STEP_MA));
				if (ktc_valid) begin
					n.ktc_ok = 1'b1;
				end
				n.win1 = cond1 ? ((q.win1 == WIN_MAX) ? q.win1 : q.win1 + WIN_W'(1)) : '0;
				n.win2 = cond2 ? ((q.win2 == WIN_MAX) ? q.win2 : q.win2 + WIN_W'(1)) : '0;
				hit[FB_SPEED] = (q.win1 == WIN_MAX);
				hit[FB_KT]    = (q.win2 == WIN_MAX);
				if (commutation) begin
					n.comm_cnt  = '0;
					n.comm_prev = q.comm_cnt;
					n.prev_ok   = 1'b1;
				end else if (q.comm_cnt != '1) begin
					n.comm_cnt = q.comm_cnt + COMM_W'(1);
				end
				hit[FB_CLOSED] = q.prev_ok &&
					(21'(q.comm_cnt) > {q.comm_prev, 1'b0});
			end
			ST_OFF: begin
				// hi-Z hold before the retry
				if (q.off_cnt != OFF_MAX) begin
					n.off_cnt = q.off_cnt + OFF_W'(1);
				end else if (run_enable) begin
					n.st  = ST_OPEN;
					clear = 1'b1;
				end else begin
					n.st = ST_IDLE;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// any enabled detector stops the drive
		if ((q.st == ST_OPEN || q.st == ST_CLOSED) && |(hit & lock_detector_enables)) begin
			n.st      = ST_OFF;
			n.off_cnt = '0;
			n.locked  = 1'b1;
		end else if ((q.st == ST_OPEN || q.st == ST_CLOSED) && !run_enable) begin
			n.st = ST_IDLE;
		end
		// any exit from open loop ends the first start
		if (q.st == ST_OPEN && n.st != ST_OPEN) begin
			n.first_done = 1'b1;
		end

		if (clear) begin
			n.locked  = 1'b0;
			n.armed   = 1'b0;
			n.zc_seen = 1'b0;
			n.halves  = 1'b0;
			n.win1    = '0;
			n.win2    = '0;
		end
		// cause bits record even when disabled; new causes win over the clear
		n.faults = (clear ? 6'h00 : q.faults) | hit;

		// bridge mode: leaving the drive passes through the surge guard when it is enabled, else goes straight to hi-Z
		if ((n.st == ST_OPEN || n.st == ST_CLOSED) && !q.oc) begin
			n.mode = BR_DRIVE;
		end else if (q.mode == BR_DRIVE && inductive_surge_guard_enable) begin
			n.mode    = BR_BRAKE;
			n.avs_cnt = AVS_CYC;
		end else if (q.mode == BR_BRAKE && q.avs_cnt != 8'h00) begin
			n.avs_cnt = q.avs_cnt - 8'h01;
		end else begin
			n.mode = BR_HIZ;
		end

		// buffered amplitude, floored at the speed-based bemf
		floor_on = mech_surge_guard_enable &&
			(!mech_surge_guard_mode || (supply_mv >= SURGE_SUPPLY_MV));
		n.spd_buf = (floor_on && speed_cmd < floor8) ? floor8 : speed_cmd;

		// tacho level: forced high while locked or quiet in open loop
		if (q.st == ST_OFF || q.locked) begin
			n.tacho = 1'b1;
		end else if (q.st == ST_OPEN && ol_quiet) begin
			n.tacho = 1'b1;
		end else begin
			n.tacho = div_lvl;
		end
	end

	always_comb begin
		half_src = 1'b0;
		if (q.st == ST_CLOSED) begin
			half_src = bemf_zero_cross;
		end else if (q.st == ST_OPEN && !ol_quiet_w) begin
			half_src = drive_half;
		end
	end

	assign ol_quiet_w = (tacho_open_loop_select != OL_PULSE) &&
		!(tacho_open_loop_select == OL_FIRST && !q.first_done);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{st: ST_IDLE, mode: BR_HIZ, tacho: 1'b1, default: '0};
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// tacho divider and bridge timing
	// ------------------------------------------------------------
	tacho_divider u_tacho (
		.clk        (clk),
		.arst_n     (arst_n),
		.half_pulse (half_src),
		.ratio_sel  (tacho_ratio_select),
		.level      (div_lvl)
	);

	pwm_bridge_timing #(
		.BASE_CYC (PWM_BASE_CYC)
	) u_pwm (
		.clk         (clk),
		.arst_n      (arst_n),
		.rate_double (pwm_rate_double),
		.dead_sel    (dead_time_select),
		.mode        (q.mode),
		.duty        (scaled_duty),
		.gate_hi     (gate_hi),
		.gate_lo     (gate_lo)
	);

	always_comb begin
		logic [15:0] p;
		p = 16'h0000;
		for (int i = 0; i < 3; i++) begin
			p = 16'(phase_wave[i]) * 16'(q.spd_buf);
			scaled_duty[i] = p[15:8];
		end
	end

	// ------------------------------------------------------------
	// status
	// ------------------------------------------------------------
	assign bridge_mode       = q.mode;
	assign spd_buf           = q.spd_buf;
	assign tacho_output      = q.tacho;
	assign rotor_locked_flag = q.locked;
	assign fault_cause_bits  = q.faults;
	assign overheat_flag     = q.ot;
	assign overcurrent_flag  = q.oc;
	assign standby_flag      = (q.st == ST_IDLE);
endmodule
`default_nettype wire

/* File: design/motor_lock_guard_fix.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verif/motor_bridge_model.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_bridge_model #(
	parameter int HALF = 20
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	// bridge state and fault knobs
	input  wire motor_guard_pkg::bridge_mode_e bridge_mode,
	input  wire logic                          no_bemf,
	input  wire logic                          stall,
	input  wire logic                          absent,
	// rotor feedback
	output logic                               drive_half,
	output logic                               bemf_zero_cross,
	output logic                               commutation,
	output logic                               ktc_valid,
	output logic [11:0]                        phase_u_current
);
	import motor_guard_pkg::*;
	logic [7:0] cnt_q;
	logic       tick;
	assign tick = cnt_q == 8'(HALF - 1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cnt_q <= 8'h00;
		else if (bridge_mode != BR_DRIVE || tick)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
	end
	// a stalled rotor neither commutates nor crosses zero
	assign drive_half      = tick;
	assign bemf_zero_cross = tick && !no_bemf && !stall;
	assign commutation     = tick && !stall;
	assign ktc_valid       = bemf_zero_cross;
	// a missing motor draws exactly the limit, never above it
	assign phase_u_current = (bridge_mode == BR_DRIVE) ? (absent ? NO_MOTOR_MA : 12'h0C8) : 12'h000;
endmodule
`default_nettype wire

/* File: verif/motor_lock_guard_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_lock_guard_asserts (
	// clock and reset
	input wire logic                          clk,
	input wire logic                          arst_n,
	// configuration and command
	input wire logic [2:0]                    lock_current_threshold,
	input wire logic [6:0]                    bemf_constant_setting,
	input wire logic [5:0]                    lock_detector_enables,
	input wire logic                          mech_surge_guard_enable,
	input wire logic                          inductive_surge_guard_enable,
	input wire logic                          mech_surge_guard_mode,
	input wire logic                          run_enable,
	input wire logic [11:0]                   low_side_current,
	input wire logic [11:0]                   speed_est,
	input wire logic [15:0]                   supply_mv,
	input wire logic                          overheat_pin,
	// watched outputs
	input wire logic [2:0]                    gate_hi,
	input wire logic [2:0]                    gate_lo,
	input wire motor_guard_pkg::bridge_mode_e bridge_mode,
	input wire logic [7:0]                    spd_buf,
	input wire logic                          tacho_output,
	input wire logic                          rotor_locked_flag,
	input wire logic [5:0]                    fault_cause_bits,
	input wire logic                          overheat_flag,
	input wire logic                          standby_flag
);
	import motor_guard_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ----
	// expected limits
	// ----
	logic [11:0] lim_ma;
	logic [18:0] bemf_raw;
	logic [7:0]  floor_v;
	logic        guard_on;
	assign lim_ma   = ({9'h000, lock_current_threshold} + 12'h001) * LOCK_CUR_STEP_MA;
	assign bemf_raw = ({7'h00, speed_est} * {12'h000, bemf_constant_setting}) >> KT_SHIFT;
	assign floor_v  = (|bemf_raw[18:8]) ? 8'hFF : bemf_raw[7:0];
	assign guard_on = mech_surge_guard_enable && (!mech_surge_guard_mode || supply_mv >= SURGE_SUPPLY_MV);
	sequence start_s;
		standby_flag && run_enable;
	endsequence
	sequence lock_s;
		$rose(rotor_locked_flag);
	endsequence
	// ----
	// properties
	// ----
	cur_lock_trip_a:
	assert property (bridge_mode == BR_DRIVE && lock_detector_enables[0] && low_side_current > lim_ma
		|-> ##[1:3] rotor_locked_flag && fault_cause_bits[0]) else $error("current lock missed");
	lock_brake_first_a:
	assert property (lock_s and inductive_surge_guard_enable |-> ##[0:2] bridge_mode == BR_BRAKE)
		else $error("no brake after lock");
	lock_goes_hiz_a:
	assert property (lock_s |-> ##[1:260] bridge_mode == BR_HIZ) else $error("no hi-z after lock");
	locked_tacho_a:
	assert property (rotor_locked_flag [*2] |-> tacho_output) else $error("tacho low while locked");
	no_overlap_a:
	assert property ((gate_hi & gate_lo) == 3'h0) else $error("both gates on");
	dead_gap_a:
	assert property ($fell(gate_hi[0]) && bridge_mode == BR_DRIVE |-> !gate_lo[0] [*5])
		else $error("dead time too short");
	restart_clear_a:
	assert property (start_s |=> fault_cause_bits == 6'h00 && !rotor_locked_flag)
		else $error("faults kept on restart");
	start_drive_a:
	assert property (start_s ##1 run_enable |=> bridge_mode == BR_DRIVE) else $error("no drive on start");
	surge_floor_a:
	assert property ((standby_flag && guard_on && $stable(floor_v)) [*3] |-> spd_buf >= floor_v)
		else $error("command under bemf floor");
	overheat_sync_a:
	assert property ($stable(overheat_pin) [*6] |-> overheat_flag == overheat_pin)
		else $error("overheat flag lags");
endmodule
bind motor_lock_guard motor_lock_guard_asserts u_asserts (
	.clk, .arst_n, .lock_current_threshold, .bemf_constant_setting, .lock_detector_enables,
	.mech_surge_guard_enable, .inductive_surge_guard_enable, .mech_surge_guard_mode, .run_enable,
	.low_side_current, .speed_est, .supply_mv, .overheat_pin, .gate_hi, .gate_lo, .bridge_mode,
	.spd_buf, .tacho_output, .rotor_locked_flag, .fault_cause_bits, .overheat_flag, .standby_flag
);
`default_nettype wire

/* File: verif/motor_lock_guard_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_lock_guard_tb;
	import motor_guard_pkg::*;
	localparam int HALF    = 20;
	// off time outlasts the brake, so hi-z is reached before a retry
	localparam int OFF_CYC = 300;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [2:0]        lock_current_threshold = 3'h7;
	logic [6:0]        phase_resistance_setting = 7'h10;
	logic [6:0]        bemf_constant_setting = 7'h10;
	logic [1:0]        bemf_band_threshold = 2'h0;
	logic [5:0]        lock_detector_enables = 6'h3F;
	logic              mech_surge_guard_enable = 1'b0;
	logic              inductive_surge_guard_enable = 1'b0;
	logic              mech_surge_guard_mode = 1'b0;
	logic [3:0]        dead_time_select = 4'h8;
	logic              pwm_rate_double = 1'b0;
	logic [1:0]        tacho_ratio_select = 2'h0;
	logic [1:0]        tacho_open_loop_select = 2'h0;
	logic              run_enable = 1'b0;
	logic [7:0]        speed_cmd = 8'hFF;
	logic [2:0][7:0]   phase_wave = {3{8'h80}};
	logic [11:0]       low_side_current = 12'h000;
	logic [15:0]       supply_mv = 16'h2EE0;
	logic              ol_rate_reached = 1'b1;
	logic              overheat_pin = 1'b0;
	logic              overcurrent_pin = 1'b0;
	logic [11:0]       speed_est, phase_u_current;
	logic [15:0]       ktc_value;
	logic              ktc_valid, drive_half, bemf_zero_cross, commutation, no_bemf, stall, absent;
	logic [2:0]        gate_hi, gate_lo;
	bridge_mode_e      bridge_mode;
	logic [7:0]        spd_buf;
	logic [5:0]        fault_cause_bits;
	logic              tacho_output, rotor_locked_flag, overheat_flag, overcurrent_flag, standby_flag;
	int                n_errors = 0;
	int                n_checks = 0;
	motor_lock_guard #(.PWM_BASE_CYC(200), .LOCK_WIN_CYC(16), .LOCK_OFF_CYC(OFF_CYC)) u_dut (.*);
	motor_bridge_model #(.HALF(HALF)) u_motor (.clk, .arst_n, .bridge_mode, .no_bemf, .stall, .absent,
		.drive_half, .bemf_zero_cross, .commutation, .ktc_valid, .phase_u_current);
	always #4 clk = ~clk;
	// ----
	// helpers
	// ----
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] want, input logic [15:0] got);
		n_checks++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, want, got);
		end
	endtask
	task automatic calm();
		speed_est = 12'h000;
		ktc_value = 16'h1000;
		absent = 1'b0;
		no_bemf = 1'b0;
		stall = 1'b0;
	endtask
	task automatic wait_lock(input int lim);
		for (int i = 0; i < lim && rotor_locked_flag !== 1'b1; i++)
			step(1);
	endtask
	task automatic halt();
		run_enable = 1'b0;
		for (int i = 0; i < 3000 && standby_flag !== 1'b1; i++)
			step(1);
		chk("standby", 16'h1, {15'h0, standby_flag});
		step(2);
	endtask
	// cycles between two rising edges of tacho (pick 0) or high gate u (pick 1)
	task automatic rise_gap(input logic pick, output int n);
		logic prev;
		logic cur;
		int   seen;
		n = 0;
		seen = 0;
		prev = 1'b1;
		for (int i = 0; i < 2000 && seen < 2; i++) begin
			step(1);
			cur = pick ? gate_hi[0] : tacho_output;
			if (seen == 1)
				n++;
			if (cur === 1'b1 && prev === 1'b0)
				seen++;
			prev = cur;
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_flags();
		chk("idle flags", 16'h5, {13'h0, standby_flag, rotor_locked_flag, tacho_output});
		overheat_pin = 1'b1;
		overcurrent_pin = 1'b1;
		step(8);
		chk("pin flags", 16'h3, {14'h0, overheat_flag, overcurrent_flag});
		overheat_pin = 1'b0;
		overcurrent_pin = 1'b0;
		step(8);
		chk("pin flags clear", 16'h0, {14'h0, overheat_flag, overcurrent_flag});
	endtask
	task automatic t_open_loop();
		logic [1:0] sel [4] = '{2'h2, 2'h1, 2'h2, 2'h0};
		logic       want [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic       low_seen;
		ol_rate_reached = 1'b0;
		for (int k = 0; k < 4; k++) begin
			tacho_open_loop_select = sel[k];
			low_seen = 1'b0;
			run_enable = 1'b1;
			for (int i = 0; i < 200; i++) begin
				step(1);
				if (tacho_output === 1'b0)
					low_seen = 1'b1;
			end
			chk("open loop tacho", {15'h0, want[k]}, {15'h0, low_seen});
			halt();
		end
		ol_rate_reached = 1'b1;
	endtask
	task automatic t_lock_current();
		lock_current_threshold = 3'h1;
		run_enable = 1'b1;
		step(100);
		low_side_current = 12'h320;
		step(10);
		chk("lock at limit", 16'h0, {15'h0, rotor_locked_flag});
		low_side_current = 12'h321;
		wait_lock(10);
		chk("current lock", 16'h41, {9'h0, rotor_locked_flag, fault_cause_bits});
		step(3);
		chk("hi-z without brake", 16'(BR_HIZ), 16'(bridge_mode));
		low_side_current = 12'h000;
		step(OFF_CYC + 120);
		chk("retry clears", 16'h0, {9'h0, rotor_locked_flag, fault_cause_bits});
		lock_detector_enables = 6'h3E;
		low_side_current = 12'h321;
		step(20);
		chk("disabled detector", 16'h1, {9'h0, rotor_locked_flag, fault_cause_bits});
		low_side_current = 12'h000;
		lock_detector_enables = 6'h3F;
		halt();
	endtask
	task automatic t_detectors();
		inductive_surge_guard_enable = 1'b1;
		for (int b = 1; b < 6; b++) begin
			absent = (b == 3);
			no_bemf = (b == 4);
			run_enable = 1'b1;
			step(100);
			speed_est = (b == 1) ? 12'hFFF : 12'h000;
			ktc_value = (b == 2) ? 16'h2000 : 16'h1000;
			stall = (b == 5);
			wait_lock(300);
			chk("lock cause", 16'h40 | (16'h1 << b), {9'h0, rotor_locked_flag, fault_cause_bits});
			calm();
			halt();
		end
	endtask
	task automatic t_tacho_pwm();
		int n;
		run_enable = 1'b1;
		step(100);
		for (int k = 0; k < 4; k++) begin
			tacho_ratio_select = 2'(k);
			rise_gap(1'b0, n);
			rise_gap(1'b0, n);
			chk("tacho period", 16'(HALF * ((k == 3) ? 6 : k + 2)), 16'(n));
		end
		for (int k = 0; k < 2; k++) begin
			pwm_rate_double = k[0];
			rise_gap(1'b1, n);
			rise_gap(1'b1, n);
			chk("pwm period", 16'(200 >> k), 16'(n));
		end
		// low gate of phase u returns one dead time after the high gate falls
		for (int i = 0; i < 400 && gate_hi[0] !== 1'b1; i++)
			step(1);
		for (int i = 0; i < 400 && gate_hi[0] !== 1'b0; i++)
			step(1);
		n = 0;
		for (int i = 0; i < 400 && gate_lo[0] !== 1'b1; i++) begin
			step(1);
			n++;
		end
		chk("dead time", 16'((32'(dead_time_select) + 32'h1) * DT_STEP_CYC), 16'(n));
		halt();
	endtask
	task automatic t_surge();
		logic [1:0]  en_md [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
		logic [15:0] sup [4] = '{16'h2EE0, 16'h2EE0, 16'h5DC0, 16'h5DC0};
		logic [7:0]  want [4] = '{8'h40, 8'h10, 8'h40, 8'h10};
		speed_cmd = 8'h10;
		speed_est = 12'h100;
		for (int k = 0; k < 4; k++) begin
			{mech_surge_guard_enable, mech_surge_guard_mode} = en_md[k];
			supply_mv = sup[k];
			step(4);
			chk("buffered command", {8'h0, want[k]}, {8'h0, spd_buf});
		end
		calm();
	endtask
	initial begin
		calm();
		step(4);
		arst_n = 1'b1;
		step(2);
		t_flags();
		t_open_loop();
		t_lock_current();
		t_detectors();
		t_tacho_pwm();
		t_surge();
		tally_and_finish();
	end
	initial begin
		#480000;
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
